// file: core/sdd_defines.vh
// Purpose: Shared constants for the system descriptor decoder.
// Assumes: Descriptors arrive as two 32-bit words, both offered in the same cycle.
// Notes: Field positions refer to the word that holds the field.
// How it works
// - Clear system flag with type 2 decodes as a local table descriptor.
// - Local table privilege field is ignored and shown as zero.
// - Local table descriptor is accepted only from the global table.
// - Types 1, 3, 9 and B decode as task state segment descriptors.
// - Type bit one marks a task state segment busy or available.
// - Type bit three marks a native or legacy task state segment format.
// - Task selector register holds the selector of the running task.
// - Types 4 to 7, C, E and F decode as gate descriptors.
// - A gate pass raises a protection check request for the destination.
// - Call gates split into access byte, far pointer and word count.
// - Privilege changing call copies word count parameters between stacks.
// - Calls without privilege change copy no parameters.
// - Task, interrupt and trap gates ignore the word count.
// - Interrupt and trap entry address is destination selector plus offset.
// - Task gates request a task switch; call gates transfer control.
// - Interrupt gates clear the interrupt enable flag; trap gates keep it.
// - Task gates use only the selector, which must name a task segment.
// - Absent gate raises exception 11; wrong destination kind raises 13.
`ifndef SDD_DEFINES_VH
`define SDD_DEFINES_VH
`define SDD_TYPE_LOCAL_TABLE 4'h2
`define SDD_TYPE_TSS16_FREE 4'h1
`define SDD_TYPE_TSS16_BUSY 4'h3
`define SDD_TYPE_TSS32_FREE 4'h9
`define SDD_TYPE_TSS32_BUSY 4'hB
`define SDD_TYPE_CALL16 4'h4
`define SDD_TYPE_TASK 4'h5
`define SDD_TYPE_INTR16 4'h6
`define SDD_TYPE_TRAP16 4'h7
`define SDD_TYPE_CALL32 4'hC
`define SDD_TYPE_INTR32 4'hE
`define SDD_TYPE_TRAP32 4'hF
`define SDD_TYPE_BUSY_BIT 1
`define SDD_TYPE_NATIVE_BIT 3
`define SDD_SEL_HI 31
`define SDD_SEL_LO 16
`define SDD_OFF_LO_HI 15
`define SDD_OFF_LO_LO 0
`define SDD_OFF_HI_HI 31
`define SDD_OFF_HI_LO 16
`define SDD_PRESENT_BIT 15
`define SDD_DPL_HI 14
`define SDD_DPL_LO 13
`define SDD_SYS_BIT 12
`define SDD_TYPE_HI 11
`define SDD_TYPE_LO 8
`define SDD_WCNT_HI 4
`define SDD_WCNT_LO 0
`define SDD_BASE_HI_HI 31
`define SDD_BASE_HI_LO 24
`define SDD_GRAN_BIT 23
`define SDD_LIM_HI_HI 19
`define SDD_LIM_HI_LO 16
`define SDD_BASE_MID_HI 7
`define SDD_BASE_MID_LO 0
`define SDD_EXC_NOT_PRESENT 8'h0B
`define SDD_EXC_PROTECTION 8'h0D
`define SDD_KIND_NONE 3'h0
`define SDD_KIND_LOCAL_TABLE 3'h1
`define SDD_KIND_TSS 3'h2
`define SDD_KIND_CALL 3'h3
`define SDD_KIND_TASK 3'h4
`define SDD_KIND_INTR 3'h5
`define SDD_KIND_TRAP 3'h6
`define SDD_ZERO_DPL 2'h0
`define SDD_ZERO_WCNT 5'h00
`define SDD_ZERO_HALF 16'h0000
`define SDD_ZERO_NIBBLE 4'h0
`define SDD_ZERO_BYTE 8'h00
`endif

// file: core/sdd_fields.v
// Purpose: Splits a two-word system descriptor into its fields.
// Assumes: Pure combinational slice of words from the same clock domain.
// Notes: The same slice serves segment and gate layouts.
`timescale 1ns/100ps
`include "sdd_defines.vh"
module sdd_fields (
  input wire [31:0] i_word0,
  input wire [31:0] i_word1,
  output wire o_present,
  output wire [1:0] o_dpl,
  output wire o_system_n,
  output wire [3:0] o_type,
  output wire [15:0] o_selector,
  output wire [31:0] o_offset,
  output wire [4:0] o_word_count,
  output wire [7:0] o_access,
  output wire [31:0] o_base,
  output wire [19:0] o_limit,
  output wire o_granular
);

  // Access byte fields shared by every system descriptor.
  assign o_present = i_word1[`SDD_PRESENT_BIT];
  assign o_dpl = i_word1[`SDD_DPL_HI:`SDD_DPL_LO];
  assign o_system_n = i_word1[`SDD_SYS_BIT];
  assign o_type = i_word1[`SDD_TYPE_HI:`SDD_TYPE_LO];
  assign o_access = i_word1[`SDD_PRESENT_BIT:`SDD_TYPE_LO];

  // Gate layout: selector, split offset and word count.
  assign o_selector = i_word0[`SDD_SEL_HI:`SDD_SEL_LO];
  assign o_offset = {i_word1[`SDD_OFF_HI_HI:`SDD_OFF_HI_LO],
                     i_word0[`SDD_OFF_LO_HI:`SDD_OFF_LO_LO]};
  assign o_word_count = i_word1[`SDD_WCNT_HI:`SDD_WCNT_LO];

  // Segment layout: base and limit of a table or task segment.
  assign o_base = {i_word1[`SDD_BASE_HI_HI:`SDD_BASE_HI_LO],
                   i_word1[`SDD_BASE_MID_HI:`SDD_BASE_MID_LO],
                   i_word0[`SDD_SEL_HI:`SDD_SEL_LO]};
  assign o_limit = {i_word1[`SDD_LIM_HI_HI:`SDD_LIM_HI_LO],
                    i_word0[`SDD_OFF_LO_HI:`SDD_OFF_LO_LO]};
  assign o_granular = i_word1[`SDD_GRAN_BIT];

endmodule

// file: core/sdd_decoder.v
// Purpose: Decodes local table, task segment and gate descriptors.
// Assumes: Descriptor words and context come from core logic on i_clock.
// Notes: Results appear one cycle after i_desc_valid and hold until the next.
//   Pulses last one cycle; decoded fields hold until the next descriptor.
//   A task gate switch takes the task selector register ahead of a load.
`timescale 1ns/100ps
`include "sdd_defines.vh"
module sdd_decoder (
  input wire i_clock,
  input wire i_srst,
  input wire i_desc_valid,
  input wire [31:0] i_desc_word0,
  input wire [31:0] i_desc_word1,
  input wire i_from_global_table,
  input wire i_privilege_change,
  input wire i_target_is_code,
  input wire i_target_is_tss,
  input wire i_interrupt_enable,
  input wire i_task_load,
  input wire [15:0] i_task_selector,
  output reg o_done,
  output reg [2:0] o_kind,
  output reg o_native,
  output reg o_tss_busy,
  output reg [31:0] o_base,
  output reg [19:0] o_limit,
  output reg o_granular,
  output reg [1:0] o_descriptor_privilege_level,
  output reg [7:0] o_access,
  output reg [15:0] o_dest_selector,
  output reg [31:0] o_dest_offset,
  output reg [4:0] o_copy_count,
  output reg o_check_request,
  output reg o_task_switch,
  output reg o_transfer,
  output reg o_interrupt_enable_next,
  output reg o_exception,
  output reg [7:0] o_exception_vector,
  output reg [15:0] o_task_selector_register
);

  // Fields sliced from the descriptor offered this cycle.
  wire present;
  wire [1:0] descriptor_privilege_level;
  wire system_n;
  wire [3:0] dtype;
  wire [15:0] selector;
  wire [31:0] offset;
  wire [4:0] word_count;
  wire [7:0] access;
  wire [31:0] base;
  wire [19:0] limit;
  wire granular;

  // Next values of the registered results, and decode helpers.
  reg [2:0] kind_nxt;
  reg native_nxt;
  reg busy_nxt;
  reg [1:0] dpl_nxt;
  reg [15:0] sel_nxt;
  reg [31:0] off_nxt;
  reg [4:0] copy_nxt;
  reg check_nxt;
  reg switch_nxt;
  reg transfer_nxt;
  reg ie_nxt;
  reg exc_nxt;
  reg [7:0] vec_nxt;
  reg is_gate;
  reg dest_ok;

  // Field slicing of the incoming descriptor words.
  // One slicer serves both the segment and the gate layouts.
  sdd_fields u_fields (
    .i_word0(i_desc_word0),
    .i_word1(i_desc_word1),
    .o_present(present),
    .o_dpl(descriptor_privilege_level),
    .o_system_n(system_n),
    .o_type(dtype),
    .o_selector(selector),
    .o_offset(offset),
    .o_word_count(word_count),
    .o_access(access),
    .o_base(base),
    .o_limit(limit),
    .o_granular(granular)
  );

  // Classification of the descriptor by system flag and type code.
  // A set system flag marks a code or data descriptor, which this
  // block does not decode, so it falls to kind none and a fault.
  always @* begin
    kind_nxt = `SDD_KIND_NONE;
    if (!system_n) begin
      case (dtype)
        `SDD_TYPE_LOCAL_TABLE: begin
          kind_nxt = `SDD_KIND_LOCAL_TABLE;
        end
        `SDD_TYPE_TSS16_FREE, `SDD_TYPE_TSS16_BUSY,
        `SDD_TYPE_TSS32_FREE, `SDD_TYPE_TSS32_BUSY: begin
          kind_nxt = `SDD_KIND_TSS;
        end
        `SDD_TYPE_CALL16, `SDD_TYPE_CALL32: begin
          kind_nxt = `SDD_KIND_CALL;
        end
        `SDD_TYPE_TASK: begin
          kind_nxt = `SDD_KIND_TASK;
        end
        `SDD_TYPE_INTR16, `SDD_TYPE_INTR32: begin
          kind_nxt = `SDD_KIND_INTR;
        end
        `SDD_TYPE_TRAP16, `SDD_TYPE_TRAP32: begin
          kind_nxt = `SDD_KIND_TRAP;
        end
        default: begin
          kind_nxt = `SDD_KIND_NONE;
        end
      endcase
    end
  end

  // Gate test, format, busy state and privilege of the descriptor.
  // The format bit is passed on for every kind; only task segments
  // and gates give it a meaning.
  always @* begin
    is_gate = (kind_nxt == `SDD_KIND_CALL) || (kind_nxt == `SDD_KIND_TASK) ||
              (kind_nxt == `SDD_KIND_INTR) || (kind_nxt == `SDD_KIND_TRAP);
    // Bit three of the type tells the native format from the legacy one.
    native_nxt = dtype[`SDD_TYPE_NATIVE_BIT];
    // Only task segments carry a busy state; every other kind reads free.
    busy_nxt = 1'b0;
    if (kind_nxt == `SDD_KIND_TSS) begin
      busy_nxt = dtype[`SDD_TYPE_BUSY_BIT];
    end
    // A local table is only loaded at level zero, so its field is moot.
    if (kind_nxt == `SDD_KIND_LOCAL_TABLE) begin
      dpl_nxt = `SDD_ZERO_DPL;
    end else begin
      dpl_nxt = descriptor_privilege_level;
    end
  end

  // Gate pointer: selector and offset, cut to the gate's format.
  // Non-gates show zero so a stale pointer is never mistaken for one.
  always @* begin
    sel_nxt = `SDD_ZERO_HALF;
    off_nxt = {`SDD_ZERO_HALF, `SDD_ZERO_HALF};
    if (is_gate) begin
      sel_nxt = selector;
      if (kind_nxt == `SDD_KIND_TASK) begin
        off_nxt = {`SDD_ZERO_HALF, `SDD_ZERO_HALF};
      end else if (native_nxt) begin
        off_nxt = offset;
      end else begin
        off_nxt = {`SDD_ZERO_HALF,
                   offset[`SDD_OFF_LO_HI:`SDD_OFF_LO_LO]};
      end
    end
  end

  // Parameter copy count for call gates only.
  // Other gate kinds and calls at the same level copy nothing, so the
  // stack engine can use a zero count as a plain skip.
  always @* begin
    copy_nxt = `SDD_ZERO_WCNT;
    if (kind_nxt == `SDD_KIND_CALL) begin
      if (i_privilege_change) begin
        copy_nxt = word_count;
      end else begin
        copy_nxt = `SDD_ZERO_WCNT;
      end
    end
  end

  // Destination kind check: code for call, interrupt and trap gates,
  // a task segment for a task gate.
  always @* begin
    dest_ok = 1'b1;
    case (kind_nxt)
      `SDD_KIND_CALL, `SDD_KIND_INTR, `SDD_KIND_TRAP: begin
        dest_ok = i_target_is_code;
      end
      `SDD_KIND_TASK: begin
        dest_ok = i_target_is_tss;
      end
      default: begin
        dest_ok = 1'b1;
      end
    endcase
  end

  // Exception selection, highest priority first: unknown kind, local
  // table outside the global table, absent gate, wrong destination.
  // An absent gate reports not-present even when its target is wrong.
  always @* begin
    exc_nxt = 1'b0;
    vec_nxt = `SDD_ZERO_BYTE;
    if (kind_nxt == `SDD_KIND_NONE) begin
      exc_nxt = 1'b1;
      vec_nxt = `SDD_EXC_PROTECTION;
    end else if (kind_nxt == `SDD_KIND_LOCAL_TABLE &&
                 !i_from_global_table) begin
      exc_nxt = 1'b1;
      vec_nxt = `SDD_EXC_PROTECTION;
    end else if (is_gate && !present) begin
      exc_nxt = 1'b1;
      vec_nxt = `SDD_EXC_NOT_PRESENT;
    end else if (is_gate && !dest_ok) begin
      exc_nxt = 1'b1;
      vec_nxt = `SDD_EXC_PROTECTION;
    end
  end

  // Control transfer actions taken through a valid gate.
  // A faulting gate still asks for the check but moves nothing.
  always @* begin
    check_nxt = is_gate;
    switch_nxt = 1'b0;
    transfer_nxt = 1'b0;
    if (!exc_nxt) begin
      switch_nxt = (kind_nxt == `SDD_KIND_TASK);
      transfer_nxt = (kind_nxt == `SDD_KIND_CALL) ||
                     (kind_nxt == `SDD_KIND_INTR) ||
                     (kind_nxt == `SDD_KIND_TRAP);
    end
  end

  // Interrupt enable for the handler: a good interrupt gate clears it,
  // while a trap gate and every other kind pass the current flag on.
  always @* begin
    ie_nxt = i_interrupt_enable;
    if (!exc_nxt && (kind_nxt == `SDD_KIND_INTR)) begin
      ie_nxt = 1'b0;
    end
  end

  // One-cycle pulses that answer each accepted descriptor.
  always @(posedge i_clock) begin
    if (i_srst) begin
      o_done <= 1'b0;
      o_check_request <= 1'b0;
      o_task_switch <= 1'b0;
      o_transfer <= 1'b0;
      o_exception <= 1'b0;
    end else begin
      o_done <= i_desc_valid;
      o_check_request <= i_desc_valid && check_nxt;
      o_task_switch <= i_desc_valid && switch_nxt;
      o_transfer <= i_desc_valid && transfer_nxt;
      o_exception <= i_desc_valid && exc_nxt;
    end
  end

  // Decoded fields, held until the next accepted descriptor.
  // Holding them lets the consumers read them after the pulse is gone.
  always @(posedge i_clock) begin
    if (i_srst) begin
      o_kind <= `SDD_KIND_NONE;
      o_native <= 1'b0;
      o_tss_busy <= 1'b0;
      o_base <= {`SDD_ZERO_HALF, `SDD_ZERO_HALF};
      o_limit <= {`SDD_ZERO_NIBBLE, `SDD_ZERO_HALF};
      o_granular <= 1'b0;
      o_descriptor_privilege_level <= `SDD_ZERO_DPL;
      o_access <= `SDD_ZERO_BYTE;
      o_dest_selector <= `SDD_ZERO_HALF;
      o_dest_offset <= {`SDD_ZERO_HALF, `SDD_ZERO_HALF};
      o_copy_count <= `SDD_ZERO_WCNT;
      o_interrupt_enable_next <= 1'b0;
      o_exception_vector <= `SDD_ZERO_BYTE;
    end else if (i_desc_valid) begin
      o_kind <= kind_nxt;
      o_native <= native_nxt;
      o_tss_busy <= busy_nxt;
      o_base <= base;
      o_limit <= limit;
      o_granular <= granular;
      o_descriptor_privilege_level <= dpl_nxt;
      o_access <= access;
      o_dest_selector <= sel_nxt;
      o_dest_offset <= off_nxt;
      o_copy_count <= copy_nxt;
      o_interrupt_enable_next <= ie_nxt;
      // The vector is loaded as zero without a fault; o_exception qualifies it.
      o_exception_vector <= vec_nxt;
    end
  end

  // Task selector register: loaded by software or by a task gate switch.
  // A switch in the same cycle as a load wins, since the gate names
  // the task that actually runs next.
  always @(posedge i_clock) begin
    if (i_srst) begin
      o_task_selector_register <= `SDD_ZERO_HALF;
    end else if (i_desc_valid && switch_nxt) begin
      o_task_selector_register <= sel_nxt;
    end else if (i_task_load) begin
      o_task_selector_register <= i_task_selector;
    end
  end

endmodule

// file: bench/sdd_decoder_checker.sv
// Purpose: Concurrent checks on the system descriptor decoder ports.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes: Results are expected exactly one cycle after a descriptor.
`timescale 1ns/100ps
`include "sdd_defines.vh"
module sdd_decoder_checker (
  input wire i_clock,
  input wire i_srst,
  input wire i_desc_valid,
  input wire [31:0] i_desc_word0,
  input wire [31:0] i_desc_word1,
  input wire i_from_global_table,
  input wire i_privilege_change,
  input wire i_target_is_code,
  input wire i_target_is_tss,
  input wire i_interrupt_enable,
  input wire o_done,
  input wire [2:0] o_kind,
  input wire o_tss_busy,
  input wire [1:0] o_descriptor_privilege_level,
  input wire [31:0] o_dest_offset,
  input wire [4:0] o_copy_count,
  input wire o_check_request,
  input wire o_task_switch,
  input wire o_interrupt_enable_next,
  input wire o_exception,
  input wire [7:0] o_exception_vector,
  input wire [15:0] o_task_selector_register
);
  // Type helpers for the descriptor offered in this cycle.
  wire [3:0] ty = i_desc_word1[11:8];
  wire sys = ~i_desc_word1[12];
  wire pres = i_desc_word1[15];
  wire gate = sys & ty[2] & (ty != 4'hD);
  wire call = gate & (ty[1:0] == 2'h0);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);
  // First steps of the gate passes that the properties follow.
  sequence s_gate; i_desc_valid && gate; endsequence
  sequence s_call_up; s_gate ##0 call && i_privilege_change; endsequence
  sequence s_good_intr;
    s_gate ##0 ty[1:0] == 2'h2 && pres && i_target_is_code;
  endsequence
  sequence s_good_task;
    s_gate ##0 ty == 4'h5 && pres && i_target_is_tss;
  endsequence
  chk_done_pulse: assert property (
    !i_desc_valid |=> !o_done && !o_check_request)
    else $error("pulse outputs without a descriptor");
  chk_local_kind: assert property (
    i_desc_valid && sys && ty == 4'h2 && i_from_global_table |=>
    o_kind == `SDD_KIND_LOCAL_TABLE && o_descriptor_privilege_level == 2'h0)
    else $error("local table descriptor misdecoded");
  chk_local_place: assert property (
    i_desc_valid && sys && ty == 4'h2 && !i_from_global_table |=>
    o_exception && o_exception_vector == `SDD_EXC_PROTECTION)
    else $error("local table outside global table accepted");
  chk_tss_busy: assert property (
    i_desc_valid && sys && !ty[2] && ty[0] |=>
    o_kind == `SDD_KIND_TSS && o_tss_busy == $past(i_desc_word1[9]))
    else $error("task segment kind or busy flag wrong");
  chk_gate_check: assert property (s_gate |=> o_check_request)
    else $error("gate pass without protection check");
  chk_copy_count: assert property (
    s_call_up |=> o_copy_count == $past(i_desc_word1[4:0]))
    else $error("copy count differs from word count");
  chk_no_copy: assert property (
    i_desc_valid && !(call && i_privilege_change) |=> o_copy_count == 5'h00)
    else $error("parameters copied without privilege change");
  chk_intr_flag: assert property (
    s_good_intr |=> !o_interrupt_enable_next)
    else $error("interrupt gate kept interrupts enabled");
  chk_trap_flag: assert property (s_gate ##0 ty[1:0] == 2'h3 |=>
    o_interrupt_enable_next == $past(i_interrupt_enable))
    else $error("trap gate changed the interrupt flag");
  chk_absent_gate: assert property (s_gate ##0 !pres |=>
    o_exception && o_exception_vector == `SDD_EXC_NOT_PRESENT)
    else $error("absent gate without not-present fault");
  chk_legacy_off: assert property (
    s_gate ##0 !ty[3] |=> o_dest_offset[31:16] == 16'h0000)
    else $error("legacy gate offset wider than 16 bits");
  chk_task_gate: assert property (s_good_task |=> o_task_switch &&
    o_dest_offset == 32'h0 &&
    o_task_selector_register == $past(i_desc_word0[31:16]))
    else $error("task gate did not switch to its selector");
endmodule
bind sdd_decoder sdd_decoder_checker u_chk (.i_clock, .i_srst, .i_desc_valid,
  .i_desc_word0, .i_desc_word1, .i_from_global_table, .i_privilege_change,
  .i_target_is_code, .i_target_is_tss, .i_interrupt_enable, .o_done, .o_kind,
  .o_tss_busy, .o_descriptor_privilege_level, .o_dest_offset, .o_copy_count,
  .o_check_request, .o_task_switch, .o_interrupt_enable_next, .o_exception,
  .o_exception_vector, .o_task_selector_register);

// file: bench/system_descriptor_decoder_tb_top.sv
// Purpose: Self-checking bench for the system descriptor decoder.
// Assumes: Inputs change on the falling edge of a 100 ns clock.
// Notes: Expected results come from expect_of or the stimulus, never from the design.
`timescale 1ns/100ps
`include "sdd_defines.vh"
`define SDD_CHK(a, e) \
  begin \
    n_compared++; \
    if ((a) !== (e)) begin \
      miscompares++; \
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (e)); \
    end \
  end
module system_descriptor_decoder_tb_top;
  logic i_clock, i_srst, i_desc_valid, i_from_global_table, i_task_load;
  logic i_privilege_change, i_target_is_code, i_target_is_tss;
  logic i_interrupt_enable, o_done, o_native, o_tss_busy, o_granular;
  logic o_check_request, o_task_switch, o_transfer, o_exception;
  logic o_interrupt_enable_next;
  logic [31:0] i_desc_word0, i_desc_word1, o_base, o_dest_offset, w1;
  logic [15:0] i_task_selector, o_dest_selector, o_task_selector_register;
  logic [15:0] sel_r;
  logic [19:0] o_limit;
  logic [7:0] o_access, o_exception_vector;
  logic [4:0] o_copy_count;
  logic [2:0] o_kind;
  logic [1:0] o_descriptor_privilege_level;
  int miscompares, n_compared, cycles;
  int unsigned seed_r;
  wire [71:0] act_v = {o_kind, o_exception,
    o_exception ? o_exception_vector : 8'h00, o_copy_count,
    o_interrupt_enable_next, o_dest_offset, o_dest_selector,
    o_descriptor_privilege_level, o_task_switch, o_transfer,
    o_check_request, o_tss_busy};
  sdd_decoder DUT (.i_clock, .i_srst, .i_desc_valid, .i_desc_word0,
    .i_desc_word1, .i_from_global_table, .i_privilege_change,
    .i_target_is_code, .i_target_is_tss, .i_interrupt_enable, .i_task_load,
    .i_task_selector, .o_done, .o_kind, .o_native, .o_tss_busy, .o_base,
    .o_limit, .o_granular, .o_descriptor_privilege_level, .o_access,
    .o_dest_selector, .o_dest_offset, .o_copy_count, .o_check_request,
    .o_task_switch, .o_transfer, .o_interrupt_enable_next, .o_exception,
    .o_exception_vector, .o_task_selector_register);
  // Context c is {global, privilege change, code target, task target, ie}.
  function automatic logic [71:0] expect_of(input logic [31:0] w0, w1,
                                            input logic [4:0] c);
    logic [3:0] t;
    logic [2:0] k;
    logic [7:0] v;
    logic g;
    logic [31:0] off;
    t = w1[11:8];
    case (t)
      4'h2: k = `SDD_KIND_LOCAL_TABLE;
      4'h1, 4'h3, 4'h9, 4'hB: k = `SDD_KIND_TSS;
      4'h4, 4'hC: k = `SDD_KIND_CALL;
      4'h5: k = `SDD_KIND_TASK;
      4'h6, 4'hE: k = `SDD_KIND_INTR;
      4'h7, 4'hF: k = `SDD_KIND_TRAP;
      default: k = `SDD_KIND_NONE;
    endcase
    if (w1[12]) k = `SDD_KIND_NONE;
    g = k >= `SDD_KIND_CALL;
    v = 8'h00;
    if (k == 3'h0 || (k == 3'h1 && !c[4])) v = 8'h0D;
    else if (g && !w1[15]) v = 8'h0B;
    else if (g && ((k == 3'h4) ? !c[1] : !c[2])) v = 8'h0D;
    off = (!g || k == 3'h4) ? 32'h0 : {t[3] ? w1[31:16] : 16'h0000, w0[15:0]};
    return {k, v != 8'h00, v, (k == 3'h3 && c[3]) ? w1[4:0] : 5'h00,
      (k == 3'h5 && v == 8'h00) ? 1'b0 : c[0], off,
      g ? w0[31:16] : 16'h0000, (k == 3'h1) ? 2'h0 : w1[14:13],
      k == 3'h4 && v == 8'h00, (k == 3'h3 || k > 3'h4) && v == 8'h00,
      g, k == 3'h2 && t[1]};
  endfunction
  // Offers one descriptor and checks the answer one cycle later.
  task automatic op(input logic [31:0] w0, w1, input logic [4:0] c);
    logic [71:0] e;
    logic [52:0] s;
    e = expect_of(w0, w1, c);
    s = {w1[31:24], w1[7:0], w0[31:16], w1[19:16], w0[15:0], w1[23]};
    i_desc_valid = 1'b1;
    i_desc_word0 = w0;
    i_desc_word1 = w1;
    {i_from_global_table, i_privilege_change, i_target_is_code,
      i_target_is_tss, i_interrupt_enable} = c;
    @(negedge i_clock);
    `SDD_CHK(o_done, 1'b1)
    `SDD_CHK(act_v, e)
    `SDD_CHK(o_access, w1[15:8])
    if (e[71:69] == 3'h1 || e[71:69] == 3'h2)
      `SDD_CHK({o_base, o_limit, o_granular}, s)
    if (e[71:69] == 3'h2)
      `SDD_CHK(o_native, w1[11])
  endtask
  task automatic end_test(input string name);
    $display("test %s done at %0t", name, $time);
  endtask
  task automatic final_report;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Free-running clock.
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end
  // Hang guard.
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      final_report;
    end
  end
  // Main sequence.
  initial begin
    {i_srst, i_desc_valid, i_task_load, i_from_global_table} = 4'h9;
    {i_privilege_change, i_target_is_code, i_target_is_tss} = 3'h0;
    {i_interrupt_enable, i_desc_word0, i_desc_word1} = 65'h0;
    i_task_selector = 16'h0000;
    seed_r = $urandom(72);
    repeat (6) @(negedge i_clock);
    `SDD_CHK({o_done, o_kind, o_task_selector_register}, 20'h0)
    i_srst = 1'b0;
    end_test("reset");
    for (int i = 0; i < 1024; i++) begin
      w1 = $urandom;
      w1[11:8] = i[3:0];
      w1[12] = i[9] & i[8];
      op($urandom, w1, i[8:4]);
    end
    for (int i = 0; i < 400; i++) op($urandom, $urandom, 5'($urandom));
    op($urandom, 32'hFFFF_8C1F, 5'h1E);
    end_test("sweep");
    i_desc_valid = 1'b0;
    @(negedge i_clock);
    `SDD_CHK({o_done, o_check_request, o_transfer}, 3'h0)
    `SDD_CHK(o_copy_count, 5'h1F)
    sel_r = 16'($urandom);
    i_task_selector = sel_r;
    i_task_load = 1'b1;
    @(negedge i_clock);
    `SDD_CHK(o_task_selector_register, sel_r)
    i_task_selector = ~sel_r;
    op(32'hA5C3_1234, 32'h0000_8500, 5'h12);
    i_task_load = 1'b0;
    i_desc_valid = 1'b0;
    `SDD_CHK(o_task_selector_register, 16'hA5C3)
    end_test("task");
    final_report;
  end
endmodule
